// *** design/lbbe_exec.sv ***
// instruction slice executor: and with file/literal, single bit clear,
// relative branches on carry and on negative, with register file and flags
// assumes an avalon-mm master with waitrequest and one 25 MHz clock
//
// Behaviour
// - and-with-file ANDs accumulator with file byte, sets only N and Z
// - and-with-file is one word, one cycle: decode, read, process, write
// - file operand is an 8-bit address plus destination and access bits
// - single-bit clear zeroes one file bit, leaves all flags alone
// - three-bit index picks bit 0 to 7 of the byte
// - branch on carry jumps only while carry is one
// - branch on carry opcode upper byte E2, offset low byte, no flags
// - offset is doubled and added, moving whole two-byte words
// - taken target is own address plus two plus twice the offset
// - conditional branch takes one cycle, two when taken, one word
// - branch on negative, upper byte E6, jumps only while negative is one
// - and-literal ANDs accumulator with immediate into accumulator, sets N, Z
`timescale 1ns/1ns
`default_nettype none
module lbbe_exec
  import lbbe_pkg::*;
#(
  parameter int QUARTER_DIV = QUARTER_DIV_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  localparam int FILE_DEPTH = 1 << FA_W;

  lbbe_phase_if ph ();

  lbbe_quarter_seq #(
    .QUARTER_DIV(QUARTER_DIV)
  ) u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ph(ph.seq)
  );

  logic [15:0] instr_reg;
  logic [DATA_W-1:0] accum_reg;
  logic [ST_W-1:0] status_reg;
  logic [PC_W-1:0] pc_reg;
  logic [BANK_W-1:0] bank_sel_reg;
  logic [FA_W-1:0] file_addr_reg;
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  lbbe_op_e op_reg;
  logic illegal_reg;
  logic taken_reg;
  logic [FA_W-1:0] target_idx_reg;
  logic [DATA_W-1:0] operand_reg;
  logic [DATA_W-1:0] result_reg;
  logic [PC_W-1:0] branch_pc_reg;
  logic rd_ack_reg;
  logic [31:0] readdata_reg;

  lbbe_op_e op_dec;
  logic [FA_W-1:0] idx_dec;
  logic [PC_W-1:0] offset2;
  logic [31:0] merged;
  logic [31:0] rd_mux;
  logic wr_ok;
  logic act;

  // decode of the held instruction word
  always_comb
  begin
    op_dec = OP_NONE;
    if (instr_reg[15:10] == OPC_AND_FILE)
      op_dec = OP_AND_FILE;
    else if (instr_reg[15:8] == OPC_AND_LIT)
      op_dec = OP_AND_LIT;
    else if (instr_reg[15:12] == OPC_BIT_CLR)
      op_dec = OP_BIT_CLR;
    else if (instr_reg[15:8] == OPC_BR_CARRY)
      op_dec = OP_BR_CARRY;
    else if (instr_reg[15:8] == OPC_BR_NEG)
      op_dec = OP_BR_NEG;
  end

  // access bit selects bank select register or the fixed access bank
  assign idx_dec = instr_reg[ACC_POS] ? {bank_sel_reg, instr_reg[7:0]}
                                      : {ACCESS_BANK, instr_reg[7:0]};

  // sign extended and doubled offset
  assign offset2 = {{(PC_W-9){instr_reg[7]}}, instr_reg[7:0], 1'b0};

  // quarter actions only happen in the first cycle; the second is a no-op
  assign act = ph.tick && !ph.second;
  assign ph.extend = taken_reg;

  // bus: every write stalls while an instruction runs, so software and
  // the datapath never write the same register in one cycle
  assign wr_ok = avs_write && !avs_read && !ph.busy;
  assign avs_waitrequest = (avs_read && !rd_ack_reg) || (avs_write && ph.busy);
  assign avs_readdata = readdata_reg;
  assign ph.start = wr_ok && avs_address == OFF_INSTR;

  always_comb
  begin
    merged = rd_mux;
    for (int i = 0; i < 4; i++)
    begin
      if (avs_byteenable[i])
        merged[8*i +: 8] = avs_writedata[8*i +: 8];
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (avs_address)
      OFF_INSTR:
        rd_mux[15:0] = instr_reg;
      OFF_ACCUM:
        rd_mux[DATA_W-1:0] = accum_reg;
      OFF_STATUS:
        rd_mux[ST_W-1:0] = status_reg;
      OFF_PC:
        rd_mux[PC_W-1:0] = pc_reg;
      OFF_BANK:
        rd_mux[BANK_W-1:0] = bank_sel_reg;
      OFF_FILE_ADDR:
        rd_mux[FA_W-1:0] = file_addr_reg;
      OFF_FILE_DATA:
        rd_mux[DATA_W-1:0] = file_mem[file_addr_reg];
      OFF_EXEC:
      begin
        rd_mux[EX_BUSY] = ph.busy;
        rd_mux[EX_TAKEN] = taken_reg;
        rd_mux[EX_ILLEGAL] = illegal_reg;
        rd_mux[EX_SECOND] = ph.second;
        rd_mux[EX_PHASE_LSB +: 2] = ph.phase;
      end
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // reads answer on the second cycle from a registered copy
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
    end
    else
    begin
      rd_ack_reg <= avs_read && !rd_ack_reg;
      if (avs_read && !rd_ack_reg)
        readdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      instr_reg <= INSTR_RST;
    else if (ph.start)
      instr_reg <= merged[15:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      bank_sel_reg <= '0;
    else if (wr_ok && avs_address == OFF_BANK)
      bank_sel_reg <= merged[BANK_W-1:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      file_addr_reg <= '0;
    else if (wr_ok && avs_address == OFF_FILE_ADDR)
      file_addr_reg <= merged[FA_W-1:0];
  end

  // datapath pipeline over the four quarters
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      op_reg <= OP_NONE;
      illegal_reg <= 1'b0;
      target_idx_reg <= '0;
      operand_reg <= '0;
      result_reg <= '0;
      taken_reg <= 1'b0;
      branch_pc_reg <= '0;
    end
    else if (ph.start)
      taken_reg <= 1'b0;
    else if (act)
    begin
      case (ph.phase)
        Q_DECODE:
        begin
          op_reg <= op_dec;
          illegal_reg <= (op_dec == OP_NONE);
          target_idx_reg <= idx_dec;
        end
        Q_READ:
          operand_reg <= (op_reg == OP_AND_LIT) ? instr_reg[7:0] : file_mem[target_idx_reg];
        Q_PROC:
        begin
          case (op_reg)
            OP_AND_FILE, OP_AND_LIT:
              result_reg <= accum_reg & operand_reg;
            OP_BIT_CLR:
              result_reg <= operand_reg & ~(DATA_W'(1) << instr_reg[BIT_LSB +: BIT_W]);
            default:
              result_reg <= operand_reg;
          endcase
          taken_reg <= (op_reg == OP_BR_CARRY && status_reg[ST_C])
                    || (op_reg == OP_BR_NEG && status_reg[ST_N]);
          // pc already advanced past the branch word
          branch_pc_reg <= pc_reg + offset2;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      pc_reg <= '0;
    else if (wr_ok && avs_address == OFF_PC)
      pc_reg <= merged[PC_W-1:0];
    else if (act && ph.phase == Q_DECODE)
      pc_reg <= pc_reg + PC_STEP;
    else if (act && ph.phase == Q_WRITE && taken_reg)
      pc_reg <= branch_pc_reg;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      accum_reg <= '0;
    else if (wr_ok && avs_address == OFF_ACCUM)
      accum_reg <= merged[DATA_W-1:0];
    else if (act && ph.phase == Q_WRITE)
    begin
      if (op_reg == OP_AND_LIT || (op_reg == OP_AND_FILE && !instr_reg[DEST_POS]))
        accum_reg <= result_reg;
    end
  end

  // only the and forms touch flags; branches and bit clear leave them
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      status_reg <= '0;
    else if (wr_ok && avs_address == OFF_STATUS)
      status_reg <= merged[ST_W-1:0];
    else if (act && ph.phase == Q_WRITE && (op_reg == OP_AND_FILE || op_reg == OP_AND_LIT))
    begin
      status_reg[ST_N] <= result_reg[DATA_W-1];
      status_reg[ST_Z] <= (result_reg == '0);
    end
  end

  // file memory holds data only, so it has no reset
  always_ff @(posedge ref_clk)
  begin
    if (wr_ok && avs_address == OFF_FILE_DATA && avs_byteenable[0])
      file_mem[file_addr_reg] <= avs_writedata[DATA_W-1:0];
    else if (act && ph.phase == Q_WRITE)
    begin
      if (op_reg == OP_BIT_CLR || (op_reg == OP_AND_FILE && instr_reg[DEST_POS]))
        file_mem[target_idx_reg] <= result_reg;
    end
  end

endmodule : lbbe_exec
`default_nettype wire

// *** design/lbbe_phase_if.sv ***
// quarter phase handshake between the executor core and its sequencer
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none
interface lbbe_phase_if;
  logic start;
  logic extend;
  logic tick;
  logic [1:0] phase;
  logic second;
  logic busy;
  modport seq (input start, input extend, output tick, output phase, output second, output busy);
  modport core (output start, output extend, input tick, input phase, input second, input busy);
endinterface : lbbe_phase_if
`default_nettype wire

// *** design/lbbe_pkg.sv ***
// constants, offsets, opcodes and types of the instruction slice executor
// assumes nothing; imported whole by both design modules
package lbbe_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W = 21;
  localparam int BANK_W = 4;
  localparam int FA_W = BANK_W + DATA_W;
  localparam int ADDR_W = 5;
  localparam int QUARTER_DIV_DEF = 1;

  // avalon byte offsets
  localparam logic [ADDR_W-1:0] OFF_INSTR = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_ACCUM = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_PC = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_BANK = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_FILE_ADDR = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_FILE_DATA = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_EXEC = 5'h1C;

  // opcode prefixes and fields
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [7:0] OPC_AND_LIT = 8'h0B;
  localparam logic [3:0] OPC_BIT_CLR = 4'h9;
  localparam logic [7:0] OPC_BR_CARRY = 8'hE2;
  localparam logic [7:0] OPC_BR_NEG = 8'hE6;
  localparam int DEST_POS = 9;
  localparam int ACC_POS = 8;
  localparam int BIT_LSB = 9;
  localparam int BIT_W = 3;

  // status bits
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_N = 2;
  localparam int ST_W = 3;

  // exec status bits
  localparam int EX_BUSY = 0;
  localparam int EX_TAKEN = 1;
  localparam int EX_ILLEGAL = 2;
  localparam int EX_SECOND = 3;
  localparam int EX_PHASE_LSB = 4;

  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
  localparam logic [15:0] INSTR_RST = 16'h0000;

  // quarter phases
  localparam logic [1:0] Q_DECODE = 2'h0;
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_PROC = 2'h2;
  localparam logic [1:0] Q_WRITE = 2'h3;

  typedef enum {
    OP_NONE,
    OP_AND_FILE,
    OP_AND_LIT,
    OP_BIT_CLR,
    OP_BR_CARRY,
    OP_BR_NEG
  } lbbe_op_e;

  typedef enum {
    SEQ_IDLE,
    SEQ_FIRST,
    SEQ_SECOND
  } lbbe_seq_e;

endpackage : lbbe_pkg

// *** design/lbbe_quarter_seq.sv ***
// quarter phase sequencer: divider, phase counter, optional second cycle
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/1ns
`default_nettype none
module lbbe_quarter_seq
  import lbbe_pkg::*;
#(
  parameter int QUARTER_DIV = QUARTER_DIV_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  lbbe_phase_if.seq ph
);

  localparam int DIV_W = (QUARTER_DIV > 1) ? $clog2(QUARTER_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QUARTER_DIV - 1);

  lbbe_seq_e state_reg;
  logic [DIV_W-1:0] div_reg;
  logic [1:0] phase_reg;

  assign ph.busy = (state_reg != SEQ_IDLE);
  assign ph.second = (state_reg == SEQ_SECOND);
  assign ph.phase = phase_reg;
  assign ph.tick = ph.busy && (div_reg == DIV_LAST);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || state_reg == SEQ_IDLE || ph.tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + DIV_W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || state_reg == SEQ_IDLE)
      phase_reg <= Q_DECODE;
    else if (ph.tick)
      phase_reg <= phase_reg + 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_reg <= SEQ_IDLE;
    else
    begin
      case (state_reg)
        SEQ_IDLE:
          if (ph.start)
            state_reg <= SEQ_FIRST;
        SEQ_FIRST:
          if (ph.tick && phase_reg == Q_WRITE)
            state_reg <= ph.extend ? SEQ_SECOND : SEQ_IDLE;
        SEQ_SECOND:
          if (ph.tick && phase_reg == Q_WRITE)
            state_reg <= SEQ_IDLE;
        default:
          state_reg <= SEQ_IDLE;
      endcase
    end
  end

endmodule : lbbe_quarter_seq
`default_nettype wire

// *** test/lbbe_exec_test.sv ***
// self-checking bench for the instruction slice executor
// assumes lbbe_exec with QUARTER_DIV of 1 driven by the master model
`timescale 1ns/1ns
`default_nettype none
module lbbe_exec_test;
  import lbbe_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, v, e;
  logic [3:0] avs_byteenable;
  int err_total = 0;
  int samples_checked = 0;
  int w;
  // acc, literal, result, status with carry preset
  logic [31:0] lt [3] = '{32'hA35F0301, 32'hF0808005, 32'hF00F0003};
  // opcode, status, offset, taken
  logic [31:0] br [5] = '{32'hE2010501, 32'hE2040500, 32'hE6048001, 32'hE6017F00, 32'hE6077F01};
  lbbe_exec #(.QUARTER_DIV(1)) u_lbbe_exec (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  lbbe_master u_lbbe_master (.ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
    u_lbbe_master.bus_read(a, v, w);
    check(nm, v, exp);
  endtask : rd
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    u_lbbe_master.bus_write(a, d, w);
  endtask : wr
  // the stall on the following write shows how long the instruction ran
  task automatic run(input logic [15:0] ins, input int cyc);
    wr(OFF_INSTR, {16'h0000, ins});
    wr(5'h02, 32'h0);
    check("stall", 32'(w), 32'(cyc));
  endtask : run
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFF_ACCUM, 32'h0, "accum reset");
    rd(OFF_PC, 32'h0, "pc reset");
    rd(5'h02, 32'h0, "unmapped");
    foreach (lt[i])
    begin
      wr(OFF_STATUS, 32'h1);
      wr(OFF_ACCUM, {24'h0, lt[i][31:24]});
      run({OPC_AND_LIT, lt[i][23:16]}, 3);
      rd(OFF_ACCUM, {24'h0, lt[i][15:8]}, "and lit acc");
      rd(OFF_STATUS, {24'h0, lt[i][7:0]}, "and lit flags");
    end
    wr(OFF_FILE_ADDR, 32'h0FF);
    wr(OFF_FILE_DATA, 32'hC2);
    wr(OFF_ACCUM, 32'h17);
    run({OPC_AND_FILE, 2'b00, 8'hFF}, 3);
    rd(OFF_ACCUM, 32'h02, "and file acc");
    rd(OFF_FILE_DATA, 32'hC2, "and file src");
    wr(OFF_BANK, 32'h3);
    rd(OFF_BANK, 32'h3, "bank select");
    wr(OFF_FILE_ADDR, 32'h300);
    wr(OFF_FILE_DATA, 32'hF0);
    wr(OFF_ACCUM, 32'h8F);
    run({OPC_AND_FILE, 2'b11, 8'h00}, 3);
    rd(OFF_FILE_DATA, 32'h80, "and file dest");
    rd(OFF_ACCUM, 32'h8F, "and file keep");
    rd(OFF_STATUS, 32'h5, "and file flags");
    wr(OFF_ACCUM, 32'hFF);
    run({OPC_AND_FILE, 2'b00, 8'hFF}, 3);
    rd(OFF_ACCUM, 32'hC2, "access bank");
    wr(OFF_FILE_ADDR, 32'h010);
    wr(OFF_FILE_DATA, 32'hFF);
    wr(OFF_STATUS, 32'h7);
    e = 32'hFF;
    for (int b = 0; b < 8; b++)
    begin
      e[b] = 1'b0;
      run({OPC_BIT_CLR, 3'(b), 1'b0, 8'h10}, 3);
      rd(OFF_FILE_DATA, e, "bit clear");
    end
    rd(OFF_STATUS, 32'h7, "bit clear flags");
    foreach (br[i])
    begin
      wr(OFF_STATUS, {24'h0, br[i][23:16]});
      wr(OFF_PC, 32'h200);
      run({br[i][31:24], br[i][15:8]}, br[i][0] ? 7 : 3);
      e = br[i][0] ? 32'h202 + {{23{br[i][15]}}, br[i][15:8], 1'b0} : 32'h202;
      rd(OFF_PC, e & 32'h1FFFFF, "branch pc");
      rd(OFF_STATUS, {24'h0, br[i][23:16]}, "branch flags");
    end
    rd(OFF_EXEC, 32'h2, "exec taken");
    run(16'hFFFF, 3);
    rd(OFF_EXEC, 32'h4, "exec illegal");
    rd(OFF_PC, 32'h302, "illegal pc");
    give_verdict();
  end
endmodule : lbbe_exec_test
bind lbbe_exec lbbe_monitor #(.QUARTER_DIV(QUARTER_DIV)) u_lbbe_monitor (.ref_clk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);
`default_nettype wire

// *** test/lbbe_master.sv ***
// avalon-mm master model standing in for the core's software side
// assumes the slave answers through waitrequest on ref_clk
`timescale 1ns/1ns
`default_nettype none
module lbbe_master
  import lbbe_pkg::*;
(
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial
  begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  // hold until answered, then scramble the released lines
  task automatic finish_req(output int waits, output logic [31:0] d);
    waits = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
    begin
      waits++;
      @(posedge ref_clk);
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask : finish_req
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output int waits);
    logic [31:0] dummy;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    finish_req(waits, dummy);
  endtask : bus_write
  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output int waits);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    finish_req(waits, d);
  endtask : bus_read
endmodule : lbbe_master
`default_nettype wire

// *** test/lbbe_monitor.sv ***
// port checker for the instruction slice executor
// assumes it is bound to lbbe_exec, one clock
`timescale 1ns/1ns
`default_nettype none
module lbbe_monitor
  import lbbe_pkg::*;
#(
  parameter int QUARTER_DIV = QUARTER_DIV_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  localparam int SHORT = 4 * QUARTER_DIV;
  localparam int LONG = 8 * QUARTER_DIV;
  int idle_cnt_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // cycles since an instruction started, saturating once surely idle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      idle_cnt_reg <= LONG;
    else if (avs_write && !avs_waitrequest && avs_address == OFF_INSTR)
      idle_cnt_reg <= 0;
    else if (idle_cnt_reg < LONG)
      idle_cnt_reg <= idle_cnt_reg + 1;
  end
  a_read_first_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
    else $error("read answered in its first cycle");
  a_read_answer_next: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered in its second cycle");
  a_write_idle_free: assert property (avs_write && idle_cnt_reg >= LONG |-> !avs_waitrequest)
    else $error("write stalled while idle");
  a_busy_write_stall: assert property (avs_write && idle_cnt_reg < SHORT |-> avs_waitrequest)
    else $error("write accepted during an instruction");
  a_wait_has_cause: assert property (avs_waitrequest |-> avs_read || (avs_write && idle_cnt_reg < LONG))
    else $error("waitrequest without cause");
  a_stall_ends: assert property (avs_write && avs_waitrequest |-> ##[1:9] !avs_waitrequest)
    else $error("write stall too long");
  a_data_holds: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without a read");
  a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> avs_readdata == 32'h0)
    else $error("read data not cleared by reset");
endmodule : lbbe_monitor
`default_nettype wire
